// File: src/swl_map.svh
// Purpose: Offsets, field positions and reset values of the register bank
// Assumes: Included by its bare name
// Notes: Offsets are register indexes; byte address is four times the index
`ifndef SWL_MAP_SVH
`define SWL_MAP_SVH

// ----------------------------------------------------------------------
// Register indexes
// ----------------------------------------------------------------------
`define SWL_IDX_EXT01 6'h02
`define SWL_IDX_BAS1 6'h03
`define SWL_IDX_EXT23 6'h04
`define SWL_IDX_BAS2 6'h05
`define SWL_IDX_EXT45 6'h06
`define SWL_IDX_BAS3 6'h07
`define SWL_IDX_BAS4 6'h08
`define SWL_IDX_BAS5 6'h09
`define SWL_IDX_SYS 6'h0a

// ----------------------------------------------------------------------
// Extended control fields
// ----------------------------------------------------------------------
`define SWL_EXT_ODD_LSB 8
`define SWL_EXT_EVEN_LSB 0
`define SWL_EXT_AGE_BIT 6
`define SWL_EXT_LRN_BIT 5
`define SWL_EXT_CAP_MSB 4
`define SWL_EXT_MASK 16'h7f7f

// ----------------------------------------------------------------------
// System tag priority control fields
// ----------------------------------------------------------------------
`define SWL_SYS_ETX_MSB 15
`define SWL_SYS_ETX_LSB 12
`define SWL_SYS_PSRC_BIT 11
`define SWL_SYS_PREW_BIT 10
`define SWL_SYS_RV0_BIT 9
`define SWL_SYS_RV1_BIT 8
`define SWL_SYS_RVF_BIT 7
`define SWL_SYS_FID_MSB 6
`define SWL_SYS_FID_LSB 3
`define SWL_SYS_TTAG_BIT 2
`define SWL_SYS_TOS_BIT 1
`define SWL_SYS_PMGT_BIT 0

// ----------------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------------
`define SWL_RST_EXT 16'h0000
`define SWL_RST_BAS 16'h0000
`define SWL_RST_SYS 16'h0000
`define SWL_ETYPE_DISC 16'h8863
`define SWL_ETYPE_SESS 16'h8864

`endif

// File: src/swl_pkg.sv
// Purpose: Types shared by the register bank
// Assumes: Nothing
// Notes: Constants live in swl_map.svh
package swl_pkg;
  typedef logic [15:0] swl_reg_t;
  typedef logic [6:0] swl_port_cfg_t;
endpackage

// File: src/swl_regs.sv
// Purpose: APB register bank for port learning, aging and tag control
// Assumes: Learning and frame inputs come from logic on sys_clk_i
// Notes: One wait state per APB access; all outputs registered
//
// Our own choice: register access over APB.
`timescale 1ns/1ns
`include "swl_map.svh"

module swl_regs #(
  parameter int NPORT = 6,
  parameter int CNT_W = 8
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Address learning
  input wire logic [NPORT-1:0] learn_req_i,
  input wire logic [NPORT-1:0] entry_free_i,
  output logic [NPORT-1:0] learn_grant_o,
  output logic [NPORT-1:0] aging_en_o,
  // Frame classification
  input wire logic [15:0] ethertype_i,
  input wire logic mgmt_pkt_i,
  input wire logic pppoe_only_port_i,
  input wire logic [7:0] tos_i,
  output logic tx_permit_o,
  output logic is_pppoe_o,
  output logic [5:0] tos_queue_key_o,
  // Fabric configuration
  output logic [3:0] early_transmit_cycles_o,
  output logic priority_source_select_o,
  output logic tag_priority_rewrite_en_o,
  output logic replace_vlan_id_zero_o,
  output logic replace_vlan_id_one_o,
  output logic replace_vlan_id_all_ones_o,
  output logic [3:0] default_filter_id_o,
  output logic transmit_tag_select_o,
  output logic tos_width_select_o,
  output logic pppoe_mgmt_pass_o,
  output logic [16*(NPORT-1)-1:0] basic_ctrl_o
);

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function automatic swl_pkg::swl_port_cfg_t port_cfg(
    input swl_pkg::swl_reg_t ext,
    input logic odd
  );
    port_cfg = odd ? ext[`SWL_EXT_ODD_LSB +: 7] : ext[`SWL_EXT_EVEN_LSB +: 7];
  endfunction

  function automatic logic may_learn(
    input swl_pkg::swl_port_cfg_t cfg,
    input logic [CNT_W-1:0] cnt
  );
    logic [4:0] cap;
    cap = cfg[`SWL_EXT_CAP_MSB:0];
    may_learn = !cfg[`SWL_EXT_LRN_BIT] &&
                ((cap == 5'h00) || (cnt < CNT_W'(cap)));
  endfunction

  // Aging stays active unless the port's aging-off bit is set
  function automatic logic aging_on(
    input swl_pkg::swl_port_cfg_t cfg
  );
    aging_on = !cfg[`SWL_EXT_AGE_BIT];
  endfunction

  // --------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------
  swl_pkg::swl_reg_t ext_q [3];
  swl_pkg::swl_reg_t bas_q [NPORT-1];
  swl_pkg::swl_reg_t sys_q;
  logic [CNT_W-1:0] cnt_q [NPORT];
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [NPORT-1:0] grant_q;
  logic [NPORT-1:0] aging_q;
  logic permit_q;
  logic pppoe_q;
  logic [5:0] tos_key_q;

  // --------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------
  wire logic [5:0] idx = paddr_i[7:2];
  wire logic aligned = (paddr_i[1:0] == 2'h0);
  wire logic access = psel_i && penable_i;
  wire logic done = access && pready_q;
  wire logic wr_fire = done && pwrite_i && !pslverr_q;
  wire logic hit_ext01 = aligned && (idx == `SWL_IDX_EXT01);
  wire logic hit_ext23 = aligned && (idx == `SWL_IDX_EXT23);
  wire logic hit_ext45 = aligned && (idx == `SWL_IDX_EXT45);
  wire logic hit_bas1 = aligned && (idx == `SWL_IDX_BAS1);
  wire logic hit_bas2 = aligned && (idx == `SWL_IDX_BAS2);
  wire logic hit_bas3 = aligned && (idx == `SWL_IDX_BAS3);
  wire logic hit_bas4 = aligned && (idx == `SWL_IDX_BAS4);
  wire logic hit_bas5 = aligned && (idx == `SWL_IDX_BAS5);
  wire logic hit_sys = aligned && (idx == `SWL_IDX_SYS);
  wire logic [2:0] ext_hit = {hit_ext45, hit_ext23, hit_ext01};
  wire logic [4:0] bas_hit = {hit_bas5, hit_bas4, hit_bas3, hit_bas2,
                              hit_bas1};
  wire logic mapped = (|ext_hit) || (|bas_hit) || hit_sys;
  wire swl_pkg::swl_reg_t wdata16 = pwdata_i[15:0];

  // Reserved bits 15 and 7 of the extended registers read as zero
  wire swl_pkg::swl_reg_t rd_mux =
    hit_ext01 ? (ext_q[0] & `SWL_EXT_MASK) :
    hit_ext23 ? (ext_q[1] & `SWL_EXT_MASK) :
    hit_ext45 ? (ext_q[2] & `SWL_EXT_MASK) :
    hit_bas1 ? bas_q[0] :
    hit_bas2 ? bas_q[1] :
    hit_bas3 ? bas_q[2] :
    hit_bas4 ? bas_q[3] :
    hit_bas5 ? bas_q[4] :
    hit_sys ? sys_q : 16'h0000;

  // --------------------------------------------------------------------
  // APB handshake: one wait state, answer registered
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else if (access && !pready_q)
    begin
      pready_q <= 1'b1;
      pslverr_q <= !mapped;
      prdata_q <= (pwrite_i || !mapped) ? 32'h0000_0000 : {16'h0000, rd_mux};
    end
    else
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      for (int i = 0; i < 3; i++)
        ext_q[i] <= `SWL_RST_EXT;
      for (int i = 0; i < NPORT-1; i++)
        bas_q[i] <= `SWL_RST_BAS;
      sys_q <= `SWL_RST_SYS;
    end
    else if (wr_fire)
    begin
      for (int i = 0; i < 3; i++)
        if (ext_hit[i])
          ext_q[i] <= wdata16 & `SWL_EXT_MASK;
      for (int i = 0; i < NPORT-1; i++)
        if (bas_hit[i])
          bas_q[i] <= wdata16;
      if (hit_sys)
        sys_q <= wdata16;
    end
  end

  // --------------------------------------------------------------------
  // Per-port learning control and address counting
  // --------------------------------------------------------------------
  logic [NPORT-1:0] grant_d;
  logic [NPORT-1:0] aging_d;

  always_comb
  begin
    for (int p = 0; p < NPORT; p++)
    begin
      grant_d[p] = learn_req_i[p] && may_learn(port_cfg(ext_q[p/2], p[0]),
                                               cnt_q[p]);
      aging_d[p] = aging_on(port_cfg(ext_q[p/2], p[0]));
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      for (int p = 0; p < NPORT; p++)
        cnt_q[p] <= '0;
      grant_q <= '0;
      aging_q <= '0;
    end
    else
    begin
      for (int p = 0; p < NPORT; p++)
      begin
        // Count learned entries; a freed entry gives room back
        if (grant_d[p] && !entry_free_i[p] && !(&cnt_q[p]))
          cnt_q[p] <= cnt_q[p] + 1'b1;
        else if (!grant_d[p] && entry_free_i[p] && (cnt_q[p] != '0))
          cnt_q[p] <= cnt_q[p] - 1'b1;
      end
      grant_q <= grant_d;
      aging_q <= aging_d;
    end
  end

  // --------------------------------------------------------------------
  // Frame classification
  // --------------------------------------------------------------------
  wire logic pppoe_d = (ethertype_i == `SWL_ETYPE_DISC) ||
                       (ethertype_i == `SWL_ETYPE_SESS);
  wire logic mgmt_pass = sys_q[`SWL_SYS_PMGT_BIT] && mgmt_pkt_i;
  wire logic permit_d = !pppoe_only_port_i || pppoe_d || mgmt_pass;
  wire logic [5:0] tos_key_d = sys_q[`SWL_SYS_TOS_BIT] ?
                               {3'h0, tos_i[7:5]} : tos_i[7:2];

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      permit_q <= 1'b0;
      pppoe_q <= 1'b0;
      tos_key_q <= 6'h00;
    end
    else
    begin
      permit_q <= permit_d;
      pppoe_q <= pppoe_d;
      tos_key_q <= tos_key_d;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < NPORT-1; i++)
      basic_ctrl_o[16*i +: 16] = bas_q[i];
  end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign learn_grant_o = grant_q;
  assign aging_en_o = aging_q;
  assign tx_permit_o = permit_q;
  assign is_pppoe_o = pppoe_q;
  assign tos_queue_key_o = tos_key_q;
  assign early_transmit_cycles_o =
    sys_q[`SWL_SYS_ETX_MSB:`SWL_SYS_ETX_LSB];
  assign priority_source_select_o = sys_q[`SWL_SYS_PSRC_BIT];
  assign tag_priority_rewrite_en_o = sys_q[`SWL_SYS_PREW_BIT];
  assign replace_vlan_id_zero_o = sys_q[`SWL_SYS_RV0_BIT];
  assign replace_vlan_id_one_o = sys_q[`SWL_SYS_RV1_BIT];
  assign replace_vlan_id_all_ones_o = sys_q[`SWL_SYS_RVF_BIT];
  assign default_filter_id_o =
    sys_q[`SWL_SYS_FID_MSB:`SWL_SYS_FID_LSB];
  assign transmit_tag_select_o = sys_q[`SWL_SYS_TTAG_BIT];
  assign tos_width_select_o = sys_q[`SWL_SYS_TOS_BIT];
  assign pppoe_mgmt_pass_o = sys_q[`SWL_SYS_PMGT_BIT];

endmodule

// File: sim/swl_regs_assertions.sv
// Purpose: Port-level checks of the register bank
// Assumes: Bound to swl_regs, one clock
// Notes: Frame outputs lag their inputs by one cycle
`timescale 1ns/1ns
module swl_regs_assertions #(
  parameter int NPORT = 6
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // APB
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Learning and frames
  input wire logic [NPORT-1:0] learn_req_i,
  input wire logic [NPORT-1:0] learn_grant_o,
  input wire logic [15:0] ethertype_i,
  input wire logic mgmt_pkt_i,
  input wire logic pppoe_only_port_i,
  input wire logic [7:0] tos_i,
  input wire logic tx_permit_o,
  input wire logic is_pppoe_o,
  input wire logic [5:0] tos_queue_key_o,
  input wire logic tos_width_select_o,
  input wire logic pppoe_mgmt_pass_o,
  input wire logic [3:0] default_filter_id_o
);
  wire logic done = psel_i && penable_i && pready_o;
  wire logic map_ok = paddr_i[1:0] == 2'h0 && paddr_i >= 8'h08 &&
    paddr_i <= 8'h28;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("pready held two cycles");
  a_ready_wait: assert property
    (psel_i && penable_i && !$past(penable_i) |=> pready_o)
    else $error("pready late");
  a_err_unmap: assert property (done && !map_ok |-> pslverr_o)
    else $error("unmapped access not refused");
  a_err_map: assert property (done && map_ok |-> !pslverr_o)
    else $error("mapped access refused");
  a_rdata_high: assert property
    (done && !pwrite_i |-> prdata_o[31:16] == 16'h0000)
    else $error("read data high half not zero");
  a_grant_cause: assert property
    ((learn_grant_o & ~$past(learn_req_i)) == '0)
    else $error("grant without request");
  a_pppoe_class: assert property ($past(rst_b_i) |-> is_pppoe_o ==
    ($past(ethertype_i) == 16'h8863 || $past(ethertype_i) == 16'h8864))
    else $error("pppoe class wrong");
  a_tx_permit: assert property ($past(rst_b_i) |-> tx_permit_o ==
    ($past(!pppoe_only_port_i || (mgmt_pkt_i && pppoe_mgmt_pass_o)) ||
    $past(ethertype_i) == 16'h8863 || $past(ethertype_i) == 16'h8864))
    else $error("transmit permit wrong");
  a_tos_key: assert property ($past(rst_b_i) |-> tos_queue_key_o ==
    ($past(tos_width_select_o) ? {3'h0, $past(tos_i[7:5])} :
    $past(tos_i[7:2])))
    else $error("tos key wrong");
  a_fid_write: assert property
    (!$stable(default_filter_id_o) |-> $past(done && pwrite_i))
    else $error("filter id changed without write");
  c_refused: cover property (done && pslverr_o);
  c_grant: cover property (|learn_grant_o);
  c_pppoe: cover property (is_pppoe_o && tx_permit_o);
endmodule

// File: sim/swl_regs_tb.sv
// Purpose: Self-checking bench of the register bank
// Assumes: APB answer after two access cycles, registered outputs
// Notes: Register model indexed by word address
`timescale 1ns/1ns
`include "swl_map.svh"
`define CHK(n, e, a) \
  begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module swl_regs_tb;
  localparam int NPORT = 6;
  logic sys_clk_i = 0, rst_b_i = 0, psel_i = 0, penable_i = 0;
  logic pwrite_i = 0, mgmt_pkt_i = 0, pppoe_only_port_i = 0;
  logic [7:0] paddr_i = 0, tos_i = 0;
  logic [31:0] pwdata_i = 0, prdata_o, rdat;
  logic [5:0] learn_req_i = 0, entry_free_i = 0, learn_grant_o;
  logic [5:0] aging_en_o, tos_queue_key_o;
  logic [15:0] ethertype_i = 0, e, m2, m4, m6;
  logic pready_o, pslverr_o, tx_permit_o, is_pppoe_o, rerr, m, o, pp;
  logic priority_source_select_o, tag_priority_rewrite_en_o;
  logic replace_vlan_id_zero_o, replace_vlan_id_one_o;
  logic replace_vlan_id_all_ones_o, transmit_tag_select_o;
  logic tos_width_select_o, pppoe_mgmt_pass_o;
  logic [3:0] early_transmit_cycles_o, default_filter_id_o;
  logic [79:0] basic_ctrl_o;
  logic [7:0] t;
  logic [15:0] mdl [0:15] = '{default: 16'h0000};
  logic [5:0] idx [0:8] = '{`SWL_IDX_EXT01, `SWL_IDX_BAS1,
    `SWL_IDX_EXT23, `SWL_IDX_BAS2, `SWL_IDX_EXT45, `SWL_IDX_BAS3,
    `SWL_IDX_BAS4, `SWL_IDX_BAS5, `SWL_IDX_SYS};
  int miscompares = 0, cmp_count = 0, seed = 45677, cyc = 0;
  int g [0:5];
  swl_regs u_dut (.*);
  initial
  begin
    forever #25 sys_clk_i = !sys_clk_i;
  end
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      complete_run();
    end
  end
  task complete_run;
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task acc(input logic w, input logic [7:0] a, input logic [15:0] d,
    input logic ee);
    int n;
    n = 0;
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {16'($random(seed)), d};
    @(posedge sys_clk_i);
    penable_i <= 1;
    do
    begin
      @(posedge sys_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    rdat = prdata_o;
    rerr = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
    `CHK("ready", 1'b1, n < 20)
    `CHK("slverr", ee, rerr)
    if (!w && !ee) `CHK("rdata", {16'h0, mdl[a[5:2]]}, rdat)
    if (w && !ee) mdl[a[5:2]] = d & ((a[5:2] inside {2, 4, 6}) ?
      `SWL_EXT_MASK : 16'hffff);
    @(posedge sys_clk_i);
  endtask
  task burst(input logic [5:0] r, input int n);
    g = '{default: 0};
    learn_req_i <= r;
    for (int k = 0; k < n + 2; k++)
    begin
      @(posedge sys_clk_i);
      if (k == n - 1) learn_req_i <= 6'h00;
      for (int p = 0; p < 6; p++) g[p] += learn_grant_o[p];
    end
  endtask
  initial
  begin
    repeat (16) @(posedge sys_clk_i);
    rst_b_i <= 1;
    @(posedge sys_clk_i);
    for (int r = 0; r < 3; r++)
    begin
      for (int i = 0; i < 9; i++) acc(0, {idx[i], 2'h0}, 16'h0, 0);
      for (int i = 0; i < 9; i++)
        if (r < 2) acc(1, {idx[i], 2'h0}, 16'($random(seed)), 0);
      @(posedge sys_clk_i);
      m2 = mdl[2];
      m4 = mdl[4];
      m6 = mdl[6];
      e = {10'h0, ~{m6[14], m6[6], m4[14], m4[6], m2[14], m2[6]}};
      `CHK("aging", e[5:0], aging_en_o)
      `CHK("basic", {mdl[9], mdl[8], mdl[7], mdl[5], mdl[3]}, basic_ctrl_o)
      e = {early_transmit_cycles_o, priority_source_select_o,
        tag_priority_rewrite_en_o, replace_vlan_id_zero_o,
        replace_vlan_id_one_o, replace_vlan_id_all_ones_o,
        default_filter_id_o, transmit_tag_select_o, tos_width_select_o,
        pppoe_mgmt_pass_o};
      `CHK("sys", mdl[10], e)
    end
    acc(0, 8'h00, 16'h0, 1);
    acc(1, 8'h2c, 16'hffff, 1);
    acc(0, 8'h09, 16'h0, 1);
    acc(1, {`SWL_IDX_EXT01, 2'h0}, 16'h2003, 0);
    acc(1, {`SWL_IDX_EXT23, 2'h0}, 16'h0000, 0);
    burst(6'h07, 6);
    `CHK("cap", 3, g[0])
    `CHK("off", 0, g[1])
    `CHK("free", 6, g[2])
    entry_free_i <= 6'h01;
    @(posedge sys_clk_i);
    entry_free_i <= 6'h00;
    burst(6'h01, 2);
    `CHK("refill", 1, g[0])
    for (int p = 0; p < 4; p++)
    begin
      acc(1, {`SWL_IDX_SYS, 2'h0}, 16'(p), 0);
      for (int k = 0; k < 16; k++)
      begin
        e = k % 4 == 0 ? 16'h8863 : k % 4 == 1 ? 16'h8864 :
          k % 4 == 2 ? 16'h8865 : 16'($random(seed));
        {m, o, t} = 10'($random(seed));
        ethertype_i <= e;
        mgmt_pkt_i <= m;
        pppoe_only_port_i <= o;
        tos_i <= t;
        repeat (2) @(posedge sys_clk_i);
        pp = e == 16'h8863 || e == 16'h8864;
        `CHK("pppoe", pp, is_pppoe_o)
        `CHK("permit", !o || pp || (m && p[0]), tx_permit_o)
        `CHK("tosq", p[1] ? {3'h0, t[7:5]} : t[7:2], tos_queue_key_o)
      end
    end
    complete_run();
  end
endmodule
bind swl_regs swl_regs_assertions #(.NPORT(NPORT)) u_chk (.*);
